//--- dual_clock_fifo_controller.v
// Notes on behaviour
// - Push enable and write enable high at push edge store word and bit mask.
// - Pop enable high at pop edge presents next entry on the data output.
// - Pop pointer lives on the pop clock, push pointer on the push clock.
// - Pop pointer goes Gray, then two flops into the push domain.
// - Push pointer goes Gray, then two flops into the pop domain.
// - Empty, almost-empty, read error are combinational from pop-side pointers.
// - Empty-side flags follow the pop clock with no added delay.
// - Full, almost-full, write error are combinational from push-side pointers.
// - Full-side flags follow the push clock with no added delay.
// - Push port writes, pop port reads; internal pointers replace any address.
// - Push when full flags write error and drops word; pop when empty flags read error.
// - Almost thresholds use a 13-bit offset, static register or dynamic input.
// - Dedicated active-low FIFO reset is synchronised into each clock domain.
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "fifo_ctl_consts.vh"
module dual_clock_fifo_controller (
  // APB slave; pclk is also the push clock
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`APB_AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // FIFO reset
  input wire fifo_rst_n,
  // Push side
  input wire push_en,
  input wire push_we,
  input wire [`DATA_W-1:0] push_word_in,
  input wire [`DATA_W-1:0] push_bit_mask,
  input wire [`OFS_W-1:0] almost_full_offset,
  output wire full,
  output wire almost_full,
  output wire wr_err,
  output wire [15:0] push_addr,
  // Pop side
  input wire pop_clk,
  input wire pop_en,
  input wire [`OFS_W-1:0] almost_empty_offset,
  output reg [`DATA_W-1:0] pop_word_out,
  output wire empty,
  output wire almost_empty,
  output wire rd_err,
  output wire [15:0] pop_addr,
  // Interrupt
  output reg irq
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [`DATA_W-1:0] mem [0:(1<<`ADDR_W)-1];

  // ----------------------------------------
  // Resets
  // ----------------------------------------
  wire fifo_arst_n;
  wire push_rst_n;
  wire pop_rst_n;

  // Either reset clears the FIFO; the raw level is only used asynchronously
  assign fifo_arst_n = presetn & fifo_rst_n;

  rst_sync u_push_rst (
    .clk(pclk),
    .arst_n(fifo_arst_n),
    .rst_n_q(push_rst_n)
  );

  rst_sync u_pop_rst (
    .clk(pop_clk),
    .arst_n(fifo_arst_n),
    .rst_n_q(pop_rst_n)
  );

  // ----------------------------------------
  // Register file state
  // ----------------------------------------
  reg ctrl_dyn_q;
  reg [`OFS_W-1:0] af_ofs_q;
  reg [`OFS_W-1:0] ae_ofs_q;
  reg [`IRQ_W-1:0] irq_status_q;
  reg [`IRQ_W-1:0] irq_en_q;

  // ----------------------------------------
  // Push domain
  // ----------------------------------------
  reg [`PTR_W-1:0] wptr_q;
  reg [`PTR_W-1:0] wgray_q;
  // Pop-side Gray pointer, declared here because the push-side synchroniser reads it
  reg [`PTR_W-1:0] rgray_q;
  wire [`PTR_W-1:0] wptr_nxt;
  wire [`PTR_W-1:0] rptr_sync;
  wire [`PTR_W-1:0] wcount;
  wire [`OFS_W-1:0] af_ofs;
  wire push_req;
  wire push_ok;
  integer b;

  assign push_req = push_en & push_we;
  // A push against a full FIFO is dropped, not stored
  assign push_ok = push_req & ~full;
  assign wptr_nxt = wptr_q + 11'h001;
  assign wcount = wptr_q - rptr_sync;

  gray_sync #(
    .W(`PTR_W)
  ) u_rptr_sync (
    .clk(pclk),
    .rst_n(push_rst_n),
    .gray_in(rgray_q),
    .bin_out(rptr_sync)
  );

  always @(posedge pclk or negedge push_rst_n) begin
    if (!push_rst_n) begin
      wptr_q <= {`PTR_W{1'b0}};
      wgray_q <= {`PTR_W{1'b0}};
    end else if (push_ok) begin
      wptr_q <= wptr_nxt;
      wgray_q <= wptr_nxt ^ (wptr_nxt >> 1);
    end
  end

  // Masked bits keep whatever the cell held before
  always @(posedge pclk) begin
    if (push_ok) begin
      for (b = 0; b < `DATA_W; b = b + 1) begin
        if (push_bit_mask[b]) begin
          mem[wptr_q[`ADDR_W-1:0]][b] <= push_word_in[b];
        end
      end
    end
  end

  assign af_ofs = ctrl_dyn_q ? almost_full_offset : af_ofs_q;
  assign full = (wcount == `DEPTH_PTR);
  assign almost_full = ({3'b000, wcount} + {1'b0, af_ofs}) >= `DEPTH_EXT;
  assign wr_err = push_req & full;
  assign push_addr = {5'h00, wptr_q};

  // ----------------------------------------
  // Pop domain
  // ----------------------------------------
  reg [`PTR_W-1:0] rptr_q;
  reg ae_dyn_q;
  reg [`OFS_W-1:0] ae_cfg_q;
  reg cfg_taken_q;
  reg rd_tgl_q;
  reg rd_err_prev_q;
  reg [1:0] pop_flags_q;
  wire [`PTR_W-1:0] rptr_nxt;
  wire [`PTR_W-1:0] wptr_sync;
  wire [`PTR_W-1:0] rcount;
  wire [`OFS_W-1:0] ae_ofs;
  wire pop_ok;

  assign rptr_nxt = rptr_q + 11'h001;
  assign rcount = wptr_sync - rptr_q;
  assign pop_ok = pop_en & ~empty;

  gray_sync #(
    .W(`PTR_W)
  ) u_wptr_sync (
    .clk(pop_clk),
    .rst_n(pop_rst_n),
    .gray_in(wgray_q),
    .bin_out(wptr_sync)
  );

  always @(posedge pop_clk or negedge pop_rst_n) begin
    if (!pop_rst_n) begin
      rptr_q <= {`PTR_W{1'b0}};
      rgray_q <= {`PTR_W{1'b0}};
      pop_word_out <= {`DATA_W{1'b0}};
      rd_tgl_q <= 1'b0;
      rd_err_prev_q <= 1'b0;
      pop_flags_q <= 2'b11;
    end else begin
      if (pop_ok) begin
        rptr_q <= rptr_nxt;
        rgray_q <= rptr_nxt ^ (rptr_nxt >> 1);
        pop_word_out <= mem[rptr_q[`ADDR_W-1:0]];
      end
      // One toggle per run of errors, so each toggle lasts long enough for pclk
      if (rd_err && !rd_err_prev_q) begin
        rd_tgl_q <= ~rd_tgl_q;
      end
      rd_err_prev_q <= rd_err;
      // Registered copies so the status path never sees glitches
      pop_flags_q <= {almost_empty, empty};
    end
  end

  // Pop-side settings (mode bit, almost-empty offset) are taken once after each FIFO reset release;
  // software must hold them steady around that moment
  always @(posedge pop_clk or negedge pop_rst_n) begin
    if (!pop_rst_n) begin
      cfg_taken_q <= 1'b0;
      ae_dyn_q <= 1'b0;
      ae_cfg_q <= `AE_OFS_RST;
    end else if (!cfg_taken_q) begin
      cfg_taken_q <= 1'b1;
      ae_dyn_q <= ctrl_dyn_q;
      ae_cfg_q <= ae_ofs_q;
    end
  end

  assign ae_ofs = ae_dyn_q ? almost_empty_offset : ae_cfg_q;
  assign empty = (rcount == {`PTR_W{1'b0}});
  assign almost_empty = {2'b00, rcount} <= ae_ofs;
  assign rd_err = pop_en & empty;
  assign pop_addr = {5'h00, rptr_q};

  // ----------------------------------------
  // Pop-side status into pclk
  // ----------------------------------------
  reg [2:0] ps1_q;
  reg [2:0] ps2_q;
  reg [2:0] ps3_q;
  reg [2:0] pf_lvl_q;
  reg [2:0] pf_prev_q;
  reg full_prev_q;
  reg afull_prev_q;
  wire [2:0] pf_lvl_d;
  wire [`IRQ_W-1:0] irq_ev;

  // A bit moves only once the second and third stages agree
  assign pf_lvl_d = (~(ps2_q ^ ps3_q) & ps2_q) | ((ps2_q ^ ps3_q) & pf_lvl_q);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps1_q <= 3'b011;
      ps2_q <= 3'b011;
      ps3_q <= 3'b011;
      pf_lvl_q <= 3'b011;
      pf_prev_q <= 3'b011;
      full_prev_q <= 1'b0;
      afull_prev_q <= 1'b0;
    end else begin
      ps1_q <= {rd_tgl_q, pop_flags_q};
      ps2_q <= ps1_q;
      ps3_q <= ps2_q;
      pf_lvl_q <= pf_lvl_d;
      pf_prev_q <= pf_lvl_q;
      full_prev_q <= full;
      afull_prev_q <= almost_full;
    end
  end

  // Read errors closer together than the crossing latency may merge
  assign irq_ev[`IRQ_WR_ERR] = wr_err;
  assign irq_ev[`IRQ_FULL] = full & ~full_prev_q;
  assign irq_ev[`IRQ_AFULL] = almost_full & ~afull_prev_q;
  assign irq_ev[`IRQ_RD_ERR] = pf_lvl_q[2] ^ pf_prev_q[2];
  assign irq_ev[`IRQ_EMPTY] = pf_lvl_q[0] & ~pf_prev_q[0];

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  wire apb_setup;
  wire apb_wr;
  wire [`IRQ_W-1:0] irq_clr;
  wire [`IRQ_W-1:0] irq_status_d;
  reg [31:0] rdata_d;
  reg hit_d;

  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite & pready;
  assign irq_clr = (apb_wr && paddr == `REG_IRQ_CLEAR) ? pwdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
  // A new event wins over a clear in the same cycle
  assign irq_status_d = (irq_status_q & ~irq_clr) | irq_ev;

  always @* begin
    rdata_d = 32'h0000_0000;
    hit_d = 1'b1;
    case (paddr)
      `REG_CTRL: begin
        rdata_d[`CTRL_DYN_BIT] = ctrl_dyn_q;
      end
      `REG_AF_OFS: begin
        rdata_d[`OFS_W-1:0] = af_ofs_q;
      end
      `REG_AE_OFS: begin
        rdata_d[`OFS_W-1:0] = ae_ofs_q;
      end
      `REG_STATUS: begin
        rdata_d[`ST_EMPTY_BIT] = pf_lvl_q[0];
        rdata_d[`ST_AEMPTY_BIT] = pf_lvl_q[1];
        rdata_d[`ST_FULL_BIT] = full;
        rdata_d[`ST_AFULL_BIT] = almost_full;
        rdata_d[`ST_FILL_LSB+`PTR_W-1:`ST_FILL_LSB] = wcount;
      end
      `REG_IRQ_STATUS: begin
        rdata_d[`IRQ_W-1:0] = irq_status_q;
      end
      `REG_IRQ_CLEAR: begin
        rdata_d = 32'h0000_0000;
      end
      `REG_IRQ_ENABLE: begin
        rdata_d[`IRQ_W-1:0] = irq_en_q;
      end
      default: begin
        hit_d = 1'b0;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ctrl_dyn_q <= 1'b0;
      af_ofs_q <= `AF_OFS_RST;
      ae_ofs_q <= `AE_OFS_RST;
      irq_en_q <= `IRQ_EN_RST;
      irq_status_q <= {`IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      // Zero wait states: answer prepared during the setup cycle
      pready <= 1'b1;
      if (apb_setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rdata_d;
        pslverr <= ~hit_d;
      end
      if (apb_wr) begin
        case (paddr)
          `REG_CTRL: begin
            ctrl_dyn_q <= pwdata[`CTRL_DYN_BIT];
          end
          `REG_AF_OFS: begin
            af_ofs_q <= pwdata[`OFS_W-1:0];
          end
          `REG_AE_OFS: begin
            ae_ofs_q <= pwdata[`OFS_W-1:0];
          end
          `REG_IRQ_ENABLE: begin
            irq_en_q <= pwdata[`IRQ_W-1:0];
          end
          default: begin
            irq_en_q <= irq_en_q;
          end
        endcase
      end
      irq_status_q <= irq_status_d;
      irq <= |(irq_status_d & irq_en_q);
    end
  end

endmodule

//--- fifo_ctl_consts.vh
`ifndef FIFO_CTL_CONSTS_VH
`define FIFO_CTL_CONSTS_VH

// ----------------------------------------
// Storage geometry
// ----------------------------------------
`define DATA_W 40
`define ADDR_W 10
`define PTR_W 11
`define OFS_W 13
`define DEPTH_PTR 11'h0400
`define DEPTH_EXT 14'h0400

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define APB_AW 12
`define REG_CTRL 12'h000
`define REG_AF_OFS 12'h004
`define REG_AE_OFS 12'h008
`define REG_STATUS 12'h00C
`define REG_IRQ_STATUS 12'h010
`define REG_IRQ_CLEAR 12'h014
`define REG_IRQ_ENABLE 12'h018

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CTRL_DYN_BIT 0
`define AF_OFS_RST 13'h0010
`define AE_OFS_RST 13'h0010
`define ST_EMPTY_BIT 0
`define ST_AEMPTY_BIT 1
`define ST_FULL_BIT 2
`define ST_AFULL_BIT 3
`define ST_FILL_LSB 16
`define IRQ_W 5
`define IRQ_WR_ERR 0
`define IRQ_FULL 1
`define IRQ_AFULL 2
`define IRQ_RD_ERR 3
`define IRQ_EMPTY 4
`define IRQ_EN_RST 5'h00

`endif

//--- fifo_ctl_properties.sv
`timescale 1ns/1ps
`include "fifo_ctl_consts.vh"
module fifo_ctl_properties (
  // Clocks and resets
  input wire pclk,
  input wire pop_clk,
  input wire presetn,
  input wire fifo_rst_n,
  // Push side
  input wire push_en,
  input wire push_we,
  input wire full,
  input wire almost_full,
  input wire wr_err,
  input wire [15:0] push_addr,
  // Pop side
  input wire pop_en,
  input wire [`DATA_W-1:0] pop_word_out,
  input wire empty,
  input wire almost_empty,
  input wire rd_err,
  input wire [15:0] pop_addr
);
  // ----------------------------------------
  // Push domain
  // ----------------------------------------
  AST_WR_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    wr_err == (push_en && push_we && full)) else $error("write error flag wrong");
  AST_PUSH_ADV: assert property (@(posedge pclk) disable iff (!presetn || !fifo_rst_n)
    push_en && push_we && !full |=> push_addr[10:0] == $past(push_addr[10:0]) + 11'h001)
    else $error("push pointer did not advance");
  AST_FULL_HOLD: assert property (@(posedge pclk) disable iff (!presetn || !fifo_rst_n)
    push_en && push_we && full |=> $stable(push_addr)) else $error("push when full moved pointer");
  AST_FULL_RISE: assert property (@(posedge pclk) disable iff (!presetn || !fifo_rst_n)
    $rose(full) |-> $past(push_en && push_we)) else $error("full rose without a push");
  AST_FULL_AF: assert property (@(posedge pclk) disable iff (!presetn)
    full |-> almost_full) else $error("full without almost full");
  AST_FIFO_RST: assert property (@(posedge pclk) disable iff (!presetn)
    !fifo_rst_n |-> push_addr == 16'h0000 && !full && empty) else $error("fifo reset did not clear");
  // ----------------------------------------
  // Pop domain
  // ----------------------------------------
  AST_RD_ERR: assert property (@(posedge pop_clk) disable iff (!presetn)
    rd_err == (pop_en && empty)) else $error("read error flag wrong");
  AST_POP_ADV: assert property (@(posedge pop_clk) disable iff (!presetn || !fifo_rst_n)
    pop_en && !empty |=> pop_addr[10:0] == $past(pop_addr[10:0]) + 11'h001)
    else $error("pop pointer did not advance");
  AST_POP_HOLD: assert property (@(posedge pop_clk) disable iff (!presetn || !fifo_rst_n)
    !(pop_en && !empty) |=> $stable(pop_word_out) && $stable(pop_addr)) else $error("idle pop moved");
  AST_EMPTY_AE: assert property (@(posedge pop_clk) disable iff (!presetn)
    empty |-> almost_empty) else $error("empty without almost empty");
endmodule

bind dual_clock_fifo_controller fifo_ctl_properties fifo_ctl_properties_i (.pclk(pclk), .pop_clk(pop_clk),
  .presetn(presetn), .fifo_rst_n(fifo_rst_n), .push_en(push_en), .push_we(push_we), .full(full),
  .almost_full(almost_full), .wr_err(wr_err), .push_addr(push_addr), .pop_en(pop_en),
  .pop_word_out(pop_word_out), .empty(empty), .almost_empty(almost_empty), .rd_err(rd_err),
  .pop_addr(pop_addr));

//--- fifo_pop_model.sv
`timescale 1ns/1ps
`include "fifo_ctl_consts.vh"
module fifo_pop_model (
  // Pop clock and command
  input wire pop_clk,
  input wire go,
  // Pop side of the block
  input wire empty,
  input wire [`DATA_W-1:0] pop_word_out,
  output logic pop_en
);
  logic got_q;
  logic [`DATA_W-1:0] q[$];
  initial pop_en = 1'b0;
  initial got_q = 1'b0;
  // Pops even when empty if told to, so read errors can be provoked
  always @(posedge pop_clk) begin
    if (got_q) q.push_back(pop_word_out);
    got_q <= pop_en && !empty;
    pop_en <= go;
  end
endmodule

//--- gray_sync.v
`timescale 1ns/1ps
module gray_sync #(
  parameter W = 11
) (
  // Destination clock and reset
  input wire clk,
  input wire rst_n,
  // Gray pointer from the far domain
  input wire [W-1:0] gray_in,
  // Binary pointer in this domain
  output reg [W-1:0] bin_out
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  integer i;

  // ----------------------------------------
  // Two-stage capture; only sync_q reads meta_q
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= gray_in;
      sync_q <= meta_q;
    end
  end

  always @* begin
    bin_out[W-1] = sync_q[W-1];
    for (i = W - 2; i >= 0; i = i - 1) begin
      bin_out[i] = bin_out[i+1] ^ sync_q[i];
    end
  end

endmodule

//--- rst_sync.v
`timescale 1ns/1ps
module rst_sync (
  // Clock and raw reset
  input wire clk,
  input wire arst_n,
  // Reset released in step with clk
  output reg rst_n_q
);

  reg meta_q;

  // ----------------------------------------
  // Asserts at once, releases after two edges
  // ----------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      meta_q <= 1'b1;
      rst_n_q <= meta_q;
    end
  end

endmodule

//--- test_dual_clock_fifo_controller.sv
`timescale 1ns/1ps
`include "fifo_ctl_consts.vh"
module test_dual_clock_fifo_controller;
  logic pclk = 0, pop_clk = 0, presetn = 0, fifo_rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic push_en = 0, push_we = 0, go = 0, pready, pslverr, serr, full, almost_full, wr_err;
  logic empty, almost_empty, rd_err, irq, pop_en;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [39:0] push_word_in = 0, push_bit_mask = 0, pop_word_out;
  logic [15:0] push_addr, pop_addr;
  int error_cnt = 0, n_checks = 0, i, n;
  always #2.5 pclk = ~pclk;
  always #3.6 pop_clk = ~pop_clk;
  dual_clock_fifo_controller dual_clock_fifo_controller_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fifo_rst_n(fifo_rst_n), .push_en(push_en), .push_we(push_we),
    .push_word_in(push_word_in), .push_bit_mask(push_bit_mask), .almost_full_offset(13'h0005),
    .full(full), .almost_full(almost_full), .wr_err(wr_err), .push_addr(push_addr), .pop_clk(pop_clk),
    .pop_en(pop_en), .almost_empty_offset(13'h0005), .pop_word_out(pop_word_out), .empty(empty),
    .almost_empty(almost_empty), .rd_err(rd_err), .pop_addr(pop_addr), .irq(irq));
  fifo_pop_model fifo_pop_model_i (.pop_clk(pop_clk), .go(go), .empty(empty),
    .pop_word_out(pop_word_out), .pop_en(pop_en));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task chk(input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick;
    @(posedge pclk);
  endtask
  // Outputs are read half a period after the edge, once settled
  task settle;
    @(negedge pclk);
  endtask
  // Waits on pready rather than assuming zero wait states; only the watchdog ends a hang
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    tick;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    tick;
    penable <= 1;
    tick;
    while (pready !== 1'b1) tick;
    rd = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task test_regs;
    apb(0, `REG_CTRL, 0);
    chk(rd, 0);
    apb(0, `REG_AF_OFS, 0);
    chk(rd, `AF_OFS_RST);
    apb(0, `REG_AE_OFS, 0);
    chk(rd, `AE_OFS_RST);
    apb(0, `REG_IRQ_ENABLE, 0);
    chk(rd, `IRQ_EN_RST);
    apb(0, 12'h020, 0);
    chk(serr, 1);
    $display("test_regs done");
  endtask
  task test_fill_drain;
    apb(1, `REG_IRQ_ENABLE, 32'h0000_0001);
    push_bit_mask <= 40'hff_ffff_ffff;
    // Each push is driven at an edge; the fill seen half a period later is i words
    for (i = 0; i < 1024; i++) begin
      push_en <= 1;
      push_we <= 1;
      push_word_in <= i;
      settle;
      chk(almost_full, i >= 1008);
      chk(full, 0);
      tick;
    end
    settle;
    chk(full, 1);
    chk(wr_err, 1);
    tick;
    push_en <= 0;
    settle;
    chk(push_addr, 16'h0400);
    chk(irq, 1);
    tick;
    go <= 1;
    n = 0;
    while (fifo_pop_model_i.q.size() < 1024 && n < 4000) begin
      tick;
      n++;
    end
    if (n == 4000) error_cnt++;
    for (i = 0; i < 1024; i++) chk(fifo_pop_model_i.q[i], i);
    @(negedge pop_clk);
    chk(empty, 1);
    chk(rd_err, 1);
    chk(pop_addr, 16'h0400);
    tick;
    go <= 0;
    repeat (6) tick;
    settle;
    chk(full, 0);
    $display("test_fill_drain done");
  endtask
  task test_irq_clear;
    apb(0, `REG_IRQ_STATUS, 0);
    chk(rd[4:0], 5'h1f);
    apb(1, `REG_IRQ_CLEAR, 32'h0000_0001);
    settle;
    chk(irq, 0);
    apb(0, `REG_IRQ_STATUS, 0);
    chk(rd[0], 0);
    $display("test_irq_clear done");
  endtask
  task test_fifo_reset;
    // Dynamic offsets take effect on the pop side at the next FIFO reset release
    apb(1, `REG_CTRL, 32'h0000_0001);
    for (i = 0; i < 3; i++) begin
      push_en <= 1;
      push_we <= 1;
      push_word_in <= 40'h00_0000_00a0 + i;
      tick;
    end
    push_en <= 0;
    settle;
    chk(push_addr, 16'h0403);
    tick;
    fifo_rst_n <= 0;
    settle;
    chk(push_addr, 0);
    chk(empty, 1);
    tick;
    fifo_rst_n <= 1;
    repeat (6) tick;
    for (i = 0; i < 8; i++) begin
      push_en <= 1;
      push_we <= 1;
      push_word_in <= 40'h00_0000_0055 + i;
      tick;
    end
    push_en <= 0;
    repeat (6) tick;
    settle;
    chk(almost_empty, 0);
    tick;
    go <= 1;
    n = 0;
    while (fifo_pop_model_i.q.size() < 1032 && n < 100) begin
      tick;
      n++;
    end
    if (n == 100) error_cnt++;
    go <= 0;
    chk(fifo_pop_model_i.q[1024], 40'h00_0000_0055);
    chk(fifo_pop_model_i.q[1031], 40'h00_0000_005c);
    $display("test_fifo_reset done");
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    fifo_rst_n <= 1;
    repeat (6) tick;
    test_regs;
    test_fill_drain;
    test_irq_clear;
    test_fifo_reset;
    end_of_test;
  end
  initial begin
    #100000;
    error_cnt++;
    end_of_test;
  end
endmodule
